// ===== include/timer_control_pkg.sv
// Purpose: Constants and types shared by the timer control register block.
// Assumes: One system clock and a synchronous, active-high reset.
// Notes:   Every offset, field position and reset value is named here.
//
// Overview of operation
// - Half B edge field: rise, fall, both.
// - Half A edge field uses same encoding.
// - Half B freeze bit stops it when halted.
// - Half A freeze bit stops it when halted.
// - Freeze bits ignored while processor runs normally.
// - Half B enable starts counting or capture.
// - Half A enable starts counting or capture.
// - Half A invert bit inverts PWM output.
// - Converter trigger passes only while enabled.
// - Realtime counting advances only while enabled.
// - Reserved control bits read as zero.
// - Control at 0x00c; four instances 0x1000 apart.
// - Configuration: 32-bit, realtime, or two 16-bit.
// - Mode: one-shot 1, periodic 2, capture 3.
package timer_control_pkg;

  // ---------------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------------
  localparam logic [11:0] TIMER_CONTROL_OFFSET = 12'h00c; // Control word.
  localparam logic [31:0] TIMER_BASE_FIRST     = 32'h40030000; // Instance 0.
  localparam logic [31:0] TIMER_BASE_STRIDE    = 32'h00001000; // Spacing.
  localparam logic [31:0] CONTROL_RESET        = 32'h00000000; // Reset.
  localparam logic [31:0] CONTROL_WRITE_MASK   = 32'h00000f7f; // Live bits.

  // ---------------------------------------------------------------------
  // Control field positions.
  // ---------------------------------------------------------------------
  localparam int HALF_A_ENABLE_BIT      = 0;
  localparam int HALF_A_FREEZE_BIT      = 1;
  localparam int HALF_A_EDGE_LSB        = 2;
  localparam int REALTIME_ENABLE_BIT    = 4;
  localparam int HALF_A_ADC_TRIG_BIT    = 5;
  localparam int HALF_A_PWM_INVERT_BIT  = 6;
  localparam int HALF_B_ENABLE_BIT      = 8;
  localparam int HALF_B_FREEZE_BIT      = 9;
  localparam int HALF_B_EDGE_LSB        = 10;

  // ---------------------------------------------------------------------
  // Edge selection codes.
  // ---------------------------------------------------------------------
  localparam logic [1:0] EDGE_RISING   = 2'h0; // Rising edges only.
  localparam logic [1:0] EDGE_FALLING  = 2'h1; // Falling edges only.
  localparam logic [1:0] EDGE_RESERVED = 2'h2; // No edge counts.
  localparam logic [1:0] EDGE_BOTH     = 2'h3; // Either edge.

  // ---------------------------------------------------------------------
  // Configuration and mode codes.
  // ---------------------------------------------------------------------
  localparam logic [2:0] CFG_WIDE_TIMER = 3'h0; // One 32-bit timer.
  localparam logic [2:0] CFG_REALTIME   = 3'h1; // 32-bit realtime counter.
  localparam logic [1:0] MODE_ONE_SHOT  = 2'h1; // One-shot timer.
  localparam logic [1:0] MODE_PERIODIC  = 2'h2; // Periodic timer.
  localparam logic [1:0] MODE_CAPTURE   = 2'h3; // Capture.

  // Operating function of the pair of halves.
  typedef enum logic [1:0] {
    FUNC_WIDE,
    FUNC_REALTIME,
    FUNC_SPLIT,
    FUNC_NONE
  } pair_function_e;

endpackage : timer_control_pkg

// ===== include/half_ctrl_if.sv
// Purpose: Per-half control bundle between the register block and a half.
// Assumes: Driven from the control register and the mode inputs on the system clock.
// Notes:   The register side drives, the half side consumes.
interface half_ctrl_if;
  logic       enable;      // Half enabled by software.
  logic       freeze;      // Stop counting under debug halt.
  logic [1:0] edge_select; // Capture edge code.
  logic [1:0] mode;        // Mode field of this half.
  modport ctrl (output enable, freeze, edge_select, mode);
  modport half (input  enable, freeze, edge_select, mode);
endinterface : half_ctrl_if

// ===== verilog/timer_half_gate.sv
// Purpose: Gates one timer half: count enable, capture enable, edge event.
// Assumes: Capture input already synchronised by the caller.
// Notes:   Purely combinational apart from the previous-level flop.
module timer_half_gate
  import timer_control_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  // Control from the register block.
  half_ctrl_if.half ctrl,
  // Context.
  input  wire logic active_in,       // This half is in use by the config.
  input  wire logic debug_halt_in,   // Processor halted by debugger.
  input  wire logic capture_sync_in, // Synchronised capture level.
  // Results.
  output logic      count_en_out,    // Counter may advance this cycle.
  output logic      capture_en_out,  // Capture logic active.
  output logic      edge_event_out   // Selected edge seen this cycle.
);

  // ---------------------------------------------------------------------
  // Edge detection.
  // ---------------------------------------------------------------------
  logic prev_level; // Capture level one cycle ago.

  // Previous level for edge detection; zero after reset.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= capture_sync_in;
    end
  end

  wire rise_seen = capture_sync_in & ~prev_level; // Rising edge.
  wire fall_seen = ~capture_sync_in & prev_level; // Falling edge.
  wire is_capture = (ctrl.mode == MODE_CAPTURE);  // Capture mode chosen.
  // Freeze matters only while halted; normal running ignores it.
  wire stalled = ctrl.freeze & debug_halt_in;

  // The reserved code counts nothing, so a bad setting stays harmless.
  assign edge_event_out = capture_en_out &
    (((ctrl.edge_select == EDGE_RISING)  & rise_seen) |
     ((ctrl.edge_select == EDGE_FALLING) & fall_seen) |
     ((ctrl.edge_select == EDGE_BOTH) & (rise_seen | fall_seen)));

  // Enabled half counts in every mode; capture mode also enables capture.
  assign capture_en_out = ctrl.enable & active_in & is_capture;
  assign count_en_out = ctrl.enable & active_in & ~stalled;

endmodule : timer_half_gate

// ===== verilog/timer_control_register.sv
// Purpose: Timer control register and the gating it applies to the halves.
// Assumes: Register port with one-cycle strobes; single system clock.
// Notes:   Configuration and mode values arrive as inputs from elsewhere.
//
// The implementer's own choice: the strobed register port.
module timer_control_register
  import timer_control_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // Register port.
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // Configuration context from the other registers.
  input  wire logic [2:0]  timer_configuration_in,
  input  wire logic [1:0]  half_a_mode_field_in,
  input  wire logic [1:0]  half_b_mode_field_in,
  // Debug and pins.
  input  wire logic        debug_halt_in,
  input  wire logic        half_a_capture_pin_in,
  input  wire logic        half_b_capture_pin_in,
  // Timer sources.
  input  wire logic        half_a_pwm_in,
  input  wire logic        half_a_timeout_in,
  // Outputs to counters, pins and converter.
  output logic             half_a_count_en_out,
  output logic             half_b_count_en_out,
  output logic             half_a_capture_en_out,
  output logic             half_b_capture_en_out,
  output logic             half_a_edge_event_out,
  output logic             half_b_edge_event_out,
  output logic             realtime_count_en_out,
  output logic             half_a_pwm_out,
  output logic             half_a_adc_trigger_out,
  output logic [1:0]       pair_function_out
);

  // ---------------------------------------------------------------------
  // Control register.
  // ---------------------------------------------------------------------
  logic [31:0] timer_control; // Stored control bits.

  // A write hits only the control offset; the instance base is external.
  wire ctl_hit   = (reg_addr_in == TIMER_CONTROL_OFFSET);
  wire ctl_write = reg_write_in & ctl_hit; // Write accepted.

  // Reset to zero; a write lands at the edge and acts from the next cycle.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      timer_control <= CONTROL_RESET;
    end else if (ctl_write) begin
      // Masking keeps bit 7 and bits above 11 at zero.
      timer_control <= reg_wdata_in & CONTROL_WRITE_MASK;
    end
  end

  // ---------------------------------------------------------------------
  // Read path.
  // ---------------------------------------------------------------------
  // Unmapped reads answer zero, so software never sees stale data.
  wire [31:0] read_mux = ctl_hit ? timer_control : 32'h00000000;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_read_in) begin
      reg_rdata_out <= read_mux;
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------
  logic [1:0] cap_meta; // First stage; read only by the second stage.
  logic [1:0] cap_sync; // Second stage, safe for logic.

  // Two flops per capture pin before any edge logic looks at it.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cap_meta <= 2'h0;
      cap_sync <= 2'h0;
    end else begin
      cap_meta <= {half_b_capture_pin_in, half_a_capture_pin_in};
      cap_sync <= cap_meta;
    end
  end

  // ---------------------------------------------------------------------
  // Configuration decode.
  // ---------------------------------------------------------------------
  pair_function_e pair_function; // Decoded pair function.

  // Codes 4 to 7 all mean two 16-bit halves; 2 and 3 are unused.
  always_comb begin
    if (timer_configuration_in == CFG_WIDE_TIMER) begin
      pair_function = FUNC_WIDE;
    end else if (timer_configuration_in == CFG_REALTIME) begin
      pair_function = FUNC_REALTIME;
    end else if (timer_configuration_in[2]) begin
      pair_function = FUNC_SPLIT;
    end else begin
      pair_function = FUNC_NONE;
    end
  end

  assign pair_function_out = pair_function;

  // Mode 0 is reserved and leaves a half idle; other modes run it.
  wire a_mode_ok = (half_a_mode_field_in != 2'h0);
  wire b_mode_ok = (half_b_mode_field_in != 2'h0);
  // Half A runs the wide timer; half B only in split form.
  wire a_active = ((pair_function == FUNC_WIDE) |
                   (pair_function == FUNC_SPLIT)) & a_mode_ok;
  wire b_active = (pair_function == FUNC_SPLIT) & b_mode_ok;

  // ---------------------------------------------------------------------
  // Half control bundles.
  // ---------------------------------------------------------------------
  half_ctrl_if half_a_bus ();
  half_ctrl_if half_b_bus ();

  assign half_a_bus.enable      = timer_control[HALF_A_ENABLE_BIT];
  assign half_a_bus.freeze      = timer_control[HALF_A_FREEZE_BIT];
  assign half_a_bus.edge_select = timer_control[HALF_A_EDGE_LSB +: 2];
  assign half_a_bus.mode        = half_a_mode_field_in;
  assign half_b_bus.enable      = timer_control[HALF_B_ENABLE_BIT];
  assign half_b_bus.freeze      = timer_control[HALF_B_FREEZE_BIT];
  assign half_b_bus.edge_select = timer_control[HALF_B_EDGE_LSB +: 2];
  // Half B keeps its own mode field; the wide form leaves it inactive.
  assign half_b_bus.mode        = half_b_mode_field_in;

  // Half A gating.
  timer_half_gate u_half_a (
    .clk_sys_in      (clk_sys_in),
    .sys_rst_in      (sys_rst_in),
    .ctrl            (half_a_bus),
    .active_in       (a_active),
    .debug_halt_in   (debug_halt_in),
    .capture_sync_in (cap_sync[0]),
    .count_en_out    (half_a_count_en_out),
    .capture_en_out  (half_a_capture_en_out),
    .edge_event_out  (half_a_edge_event_out)
  );

  // Half B gating.
  timer_half_gate u_half_b (
    .clk_sys_in      (clk_sys_in),
    .sys_rst_in      (sys_rst_in),
    .ctrl            (half_b_bus),
    .active_in       (b_active),
    .debug_halt_in   (debug_halt_in),
    .capture_sync_in (cap_sync[1]),
    .count_en_out    (half_b_count_en_out),
    .capture_en_out  (half_b_capture_en_out),
    .edge_event_out  (half_b_edge_event_out)
  );

  // ---------------------------------------------------------------------
  // Realtime, PWM and converter trigger.
  // ---------------------------------------------------------------------
  // Realtime counting needs both the realtime form and its enable bit.
  // The realtime counter obeys the half A freeze bit under debug halt.
  assign realtime_count_en_out = (pair_function == FUNC_REALTIME) &
    timer_control[REALTIME_ENABLE_BIT] &
    ~(timer_control[HALF_A_FREEZE_BIT] & debug_halt_in);

  // Registered so the pin level comes from a flop.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      half_a_pwm_out         <= 1'b0;
      half_a_adc_trigger_out <= 1'b0;
    end else begin
      // Invert bit flips the level seen at the pin.
      half_a_pwm_out <= half_a_pwm_in ^
                        timer_control[HALF_A_PWM_INVERT_BIT];
      // Trigger is dropped unless enabled; the converter must also select
      // this timer itself before a conversion starts.
      half_a_adc_trigger_out <= half_a_timeout_in &
        timer_control[HALF_A_ADC_TRIG_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  property p_write_visible;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_write_in && ctl_hit) |=>
        timer_control == ($past(reg_wdata_in) & CONTROL_WRITE_MASK);
  endproperty
  a_write_visible: assert property (p_write_visible)
    else $error("Control write not stored.");

  property p_reserved_zero;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      reg_read_in |=> (reg_rdata_out[7] == 1'b0) &&
                      (reg_rdata_out[31:12] == 20'h00000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved control bit read as one.");

  property p_read_data;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_read_in && ctl_hit && !reg_write_in) |=>
        reg_rdata_out == $past(timer_control);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("Control read returned wrong data.");

  property p_pwm_invert;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ##1 half_a_pwm_out ==
        ($past(half_a_pwm_in) ^ $past(timer_control[HALF_A_PWM_INVERT_BIT]));
  endproperty
  a_pwm_invert: assert property (p_pwm_invert)
    else $error("PWM level not inverted as set.");

  property p_trigger_gate;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      !timer_control[HALF_A_ADC_TRIG_BIT] |=> !half_a_adc_trigger_out;
  endproperty
  a_trigger_gate: assert property (p_trigger_gate)
    else $error("Converter trigger issued while disabled.");

  property p_realtime_gate;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      realtime_count_en_out |-> timer_control[REALTIME_ENABLE_BIT] &&
                                (timer_configuration_in == CFG_REALTIME);
  endproperty
  a_realtime_gate: assert property (p_realtime_gate)
    else $error("Realtime counting without enable.");

  property p_freeze_a;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (debug_halt_in && timer_control[HALF_A_FREEZE_BIT]) |->
        !half_a_count_en_out;
  endproperty
  a_freeze_a: assert property (p_freeze_a)
    else $error("Half A counted while frozen.");

  property p_freeze_b;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (debug_halt_in && timer_control[HALF_B_FREEZE_BIT]) |->
        !half_b_count_en_out;
  endproperty
  a_freeze_b: assert property (p_freeze_b)
    else $error("Half B counted while frozen.");

  property p_run_ignores_freeze;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (!debug_halt_in && timer_control[HALF_A_ENABLE_BIT] && a_active) |->
        half_a_count_en_out;
  endproperty
  a_run_ignores_freeze: assert property (p_run_ignores_freeze)
    else $error("Half A stopped while processor runs.");

  property p_enable_b;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      !timer_control[HALF_B_ENABLE_BIT] |->
        !half_b_count_en_out && !half_b_capture_en_out;
  endproperty
  a_enable_b: assert property (p_enable_b)
    else $error("Half B active while disabled.");

  property p_enable_a;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      !timer_control[HALF_A_ENABLE_BIT] |->
        !half_a_count_en_out && !half_a_capture_en_out;
  endproperty
  a_enable_a: assert property (p_enable_a)
    else $error("Half A active while disabled.");

  property p_edge_reserved_a;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (timer_control[HALF_A_EDGE_LSB +: 2] == EDGE_RESERVED) |->
        !half_a_edge_event_out;
  endproperty
  a_edge_reserved_a: assert property (p_edge_reserved_a)
    else $error("Reserved edge code produced an event on half A.");

  property p_edge_fall_b;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (timer_control[HALF_B_EDGE_LSB +: 2] == EDGE_FALLING &&
       half_b_edge_event_out) |-> !cap_sync[1];
  endproperty
  a_edge_fall_b: assert property (p_edge_fall_b)
    else $error("Half B falling event on a high level.");

  property p_split_decode;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      timer_configuration_in[2] |-> pair_function_out == FUNC_SPLIT;
  endproperty
  a_split_decode: assert property (p_split_decode)
    else $error("Split configuration misdecoded.");

  property p_mode_reserved;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (half_b_mode_field_in == 2'h0) |-> !half_b_count_en_out;
  endproperty
  a_mode_reserved: assert property (p_mode_reserved)
    else $error("Half B ran with reserved mode.");

  property p_read_unmapped;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_read_in && !ctl_hit) |=> (reg_rdata_out == 32'h00000000);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("Unmapped read returned nonzero data.");

  property p_trigger_pass;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (half_a_timeout_in && timer_control[HALF_A_ADC_TRIG_BIT]) |=>
        half_a_adc_trigger_out;
  endproperty
  a_trigger_pass: assert property (p_trigger_pass)
    else $error("Enabled converter trigger was lost.");

  property p_realtime_run;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ((pair_function == FUNC_REALTIME) &&
       timer_control[REALTIME_ENABLE_BIT] && !debug_halt_in) |->
        realtime_count_en_out;
  endproperty
  a_realtime_run: assert property (p_realtime_run)
    else $error("Realtime counting stopped while enabled.");

  property p_capture_a;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      half_a_capture_en_out |->
        (half_a_mode_field_in == MODE_CAPTURE) && a_active;
  endproperty
  a_capture_a: assert property (p_capture_a)
    else $error("Half A capture active outside capture mode.");

  property p_wide_b_idle;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      (pair_function != FUNC_SPLIT) |->
        !half_b_count_en_out && !half_b_capture_en_out;
  endproperty
  a_wide_b_idle: assert property (p_wide_b_idle)
    else $error("Half B ran outside the split form.");

endmodule : timer_control_register

// ===== tb/converter_trigger_model.sv
// Purpose: Converter side that takes the timer trigger as a start request.
// Assumes: The trigger is a one-cycle level on the system clock.
// Notes:   A start counts only when the converter is on and picks this timer.
module converter_trigger_model (
  // Clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  // Converter set-up and trigger.
  input  wire logic       converter_enable_in,
  input  wire logic       converter_event_select_in,
  input  wire logic       trigger_in,
  // Starts seen.
  output logic      [7:0] start_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // A trigger alone is not enough; the converter must also be set up.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      start_count_out <= 8'h00;
    end else if (trigger_in && converter_enable_in &&
                 converter_event_select_in) begin
      start_count_out <= start_count_out + 8'h01;
    end
  end
endmodule : converter_trigger_model

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the timer control register block.
// Assumes: One 200 MHz clock; register port with one-cycle strobes.
// Notes:   Outputs are sampled 1 ns after the edge so that updates settle.
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_control_pkg::*;
  // ---------------------------------------------------------------------
  // Stimulus and observed signals.
  // ---------------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdat;
  logic [2:0]  cfg = 3'h0;
  logic [1:0]  mode_a = 2'h0, mode_b = 2'h0, func;
  logic        halt = 1'b0, cap_a = 1'b0, cap_b = 1'b0, pwm = 1'b0;
  logic        tmo = 1'b0, conv_en = 1'b1, conv_sel = 1'b1;
  logic        cnt_a, cnt_b, capt_a, capt_b, ev_a, ev_b, rtc, pwm_o, trig;
  logic [31:0] rdata;
  logic [7:0]  starts;
  int          n_fail = 0, n_tests = 0, edges_a = 0, edges_b = 0;
  // Free-running system clock.
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Edge events are pulses, so they are tallied on every edge.
  always @(posedge clk) begin
    if (ev_a === 1'b1) edges_a++;
    if (ev_b === 1'b1) edges_b++;
  end
  timer_control_register DUT (
    .clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
    .reg_rdata_out(rdata), .timer_configuration_in(cfg),
    .half_a_mode_field_in(mode_a), .half_b_mode_field_in(mode_b),
    .debug_halt_in(halt), .half_a_capture_pin_in(cap_a),
    .half_b_capture_pin_in(cap_b), .half_a_pwm_in(pwm),
    .half_a_timeout_in(tmo), .half_a_count_en_out(cnt_a),
    .half_b_count_en_out(cnt_b), .half_a_capture_en_out(capt_a),
    .half_b_capture_en_out(capt_b), .half_a_edge_event_out(ev_a),
    .half_b_edge_event_out(ev_b), .realtime_count_en_out(rtc),
    .half_a_pwm_out(pwm_o), .half_a_adc_trigger_out(trig),
    .pair_function_out(func));
  converter_trigger_model partner (
    .clk_sys_in(clk), .sys_rst_in(rst), .converter_enable_in(conv_en),
    .converter_event_select_in(conv_sel), .trigger_in(trig),
    .start_count_out(starts));
  // ---------------------------------------------------------------------
  // Bus cycles and helpers.
  // ---------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  // Sets the halt level, then checks both count enables.
  task automatic chk_en(input logic h, input logic ea, input logic eb);
    @(posedge clk);
    halt <= h;
    #1;
    `CHK("count_a", ea, cnt_a)
    `CHK("count_b", eb, cnt_b)
  endtask : chk_en
  // One timeout pulse, then time for the registered trigger to land.
  task automatic pulse;
    @(posedge clk);
    tmo <= 1'b1;
    @(posedge clk);
    tmo <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse
  // ---------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------
  task automatic t_reg;
    rd(TIMER_CONTROL_OFFSET, rdat);
    `CHK("ctl_reset", 32'h0, rdat)
    wr(TIMER_CONTROL_OFFSET, 32'hffffffff);
    rd(TIMER_CONTROL_OFFSET, rdat);
    `CHK("ctl_mask", 32'h00000f7f, rdat)
    wr(12'h008, 32'h0);
    rd(TIMER_CONTROL_OFFSET, rdat);
    `CHK("ctl_kept", 32'h00000f7f, rdat)
    rd(12'h008, rdat);
    `CHK("unmapped", 32'h0, rdat)
    wr(TIMER_CONTROL_OFFSET, 32'h0);
  endtask : t_reg
  task automatic t_func;
    logic [2:0] cv[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    pair_function_e fv[5] = '{FUNC_WIDE, FUNC_REALTIME, FUNC_NONE,
                              FUNC_SPLIT, FUNC_SPLIT};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      cfg <= cv[i];
      #1;
      `CHK("pair_function", fv[i], func)
    end
  endtask : t_func
  task automatic t_stall;
    cfg    <= 3'h0;
    mode_a <= 2'h1;
    wr(TIMER_CONTROL_OFFSET, 32'h3);
    chk_en(1'b0, 1'b1, 1'b0);
    chk_en(1'b1, 1'b0, 1'b0);
    wr(TIMER_CONTROL_OFFSET, 32'h1);
    chk_en(1'b1, 1'b1, 1'b0);
    wr(TIMER_CONTROL_OFFSET, 32'h0);
    chk_en(1'b0, 1'b0, 1'b0);
    cfg    <= 3'h4;
    mode_b <= 2'h2;
    wr(TIMER_CONTROL_OFFSET, 32'h300);
    chk_en(1'b1, 1'b0, 1'b0);
    chk_en(1'b0, 1'b0, 1'b1);
    wr(TIMER_CONTROL_OFFSET, 32'h100);
    chk_en(1'b1, 1'b0, 1'b1);
    mode_a <= 2'h0;
    wr(TIMER_CONTROL_OFFSET, 32'h1);
    chk_en(1'b0, 1'b0, 1'b0);
    mode_a <= 2'h3;
    wr(TIMER_CONTROL_OFFSET, 32'h1);
    `CHK("capture_a", 1'b1, capt_a)
    `CHK("capture_b", 1'b0, capt_b)
  endtask : t_stall
  task automatic t_edge;
    int ea[4] = '{1, 1, 0, 2};
    int a0, b0;
    mode_b <= 2'h3;
    for (int c = 0; c < 4; c++) begin
      wr(TIMER_CONTROL_OFFSET, (c << 10) | 32'h100 | (c << 2) | 32'h1);
      repeat (6) @(posedge clk);
      a0 = edges_a;
      b0 = edges_b;
      cap_a <= 1'b1;
      cap_b <= 1'b1;
      repeat (6) @(posedge clk);
      cap_a <= 1'b0;
      cap_b <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      `CHK("edges_a", ea[c], edges_a - a0)
      `CHK("edges_b", ea[c], edges_b - b0)
    end
  endtask : t_edge
  task automatic t_out;
    logic [7:0] s0;
    pwm <= 1'b1;
    wr(TIMER_CONTROL_OFFSET, 32'h40);
    @(posedge clk);
    #1;
    `CHK("pwm_inverted", 1'b0, pwm_o)
    wr(TIMER_CONTROL_OFFSET, 32'h20);
    @(posedge clk);
    #1;
    `CHK("pwm_plain", 1'b1, pwm_o)
    s0 = starts;
    pulse();
    `CHK("starts_on", s0 + 8'h01, starts)
    conv_sel <= 1'b0;
    pulse();
    `CHK("starts_unselected", s0 + 8'h01, starts)
    conv_sel <= 1'b1;
    conv_en  <= 1'b0;
    pulse();
    `CHK("starts_disabled", s0 + 8'h01, starts)
    conv_en  <= 1'b1;
    wr(TIMER_CONTROL_OFFSET, 32'h0);
    pulse();
    `CHK("starts_off", s0 + 8'h01, starts)
  endtask : t_out
  task automatic t_rtc;
    cfg <= 3'h1;
    wr(TIMER_CONTROL_OFFSET, 32'h10);
    `CHK("realtime_on", 1'b1, rtc)
    wr(TIMER_CONTROL_OFFSET, 32'h0);
    `CHK("realtime_off", 1'b0, rtc)
  endtask : t_rtc
  // ---------------------------------------------------------------------
  // Verdict and sequencing.
  // ---------------------------------------------------------------------
  task automatic complete_run;
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // The whole sequence needs about 160 cycles; 20 us leaves ample margin.
  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reg();
    t_func();
    t_stall();
    t_edge();
    t_out();
    t_rtc();
    complete_run();
  end
endmodule : tb_top
